// File: common/fma_pkg.sv
package fma_pkg;
	// Clock and modem timing
	localparam int CLK_HZ = 100_000_000;
	localparam int MODEM_BAUD = 1200;
	localparam int MARK_HZ = 1200;
	localparam int SPACE_HZ = 2200;
	localparam int HOST_BAUD = 1200;
	localparam int BIT_CYC = CLK_HZ / MODEM_BAUD;
	localparam int MARK_HALF_CYC = CLK_HZ / (2 * MARK_HZ);
	localparam int SPACE_HALF_CYC = CLK_HZ / (2 * SPACE_HZ);
	localparam int HOST_BIT_CYC = CLK_HZ / HOST_BAUD;
	// Stop bit end plus 1.5 bits, measured from mid stop bit
	localparam int HOST_QUEUE_BITS = 2;
	localparam int CNT_W = 20;
	// Character framing: start, 8 data, odd parity, stop
	localparam int CHAR_BITS = 11;
	localparam int DATA_BITS = 8;
	// Queue geometry
	localparam int FIFO_DEPTH = 32;
	localparam int FIFO_AW = 5;
	// Register byte offsets
	localparam logic [7:0] OFS_CFG = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_TXWR = 8'h08;
	localparam logic [7:0] OFS_RXRD = 8'h0c;
	localparam logic [3:0] CFG_RESET = 4'h0;
	localparam int CFG_W = 4;
	// Status field positions
	localparam int ST_CD = 0;
	localparam int ST_CTS = 1;
	localparam int ST_MOD_EN = 2;
	localparam int ST_DEMOD_EN = 3;
	localparam int ST_TX_EMPTY = 4;
	localparam int ST_TX_FULL = 5;
	localparam int ST_RX_EMPTY = 6;
	localparam int ST_RX_FULL = 7;
	localparam int ST_TX_LVL = 8;
	localparam int ST_RX_LVL = 16;
	localparam int RXRD_EMPTY = 8;

	typedef enum logic [1:0] {ARB_IDLE, ARB_RECEIVE, ARB_TRANSMIT, ARB_DUPLEX} fma_arb_t;

	// Configuration word, lsb first: request, internal loop, external loop, SPI only
	typedef struct packed {
		logic spi_only;
		logic external_loopback_enable;
		logic int_loop;
		logic rts;
	} fma_cfg_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} fma_byte_t;
endpackage

// File: verilog/fma_fifo.sv
`timescale 1ns/1ps
module fma_fifo import fma_pkg::*; (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Fill side
	input wire logic push,
	input wire logic [7:0] din,
	// Drain side
	input wire logic pop,
	output logic [7:0] dout,
	// Flags
	output logic empty,
	output logic full,
	output logic [FIFO_AW:0] level
);
	typedef struct packed {
		logic [FIFO_DEPTH-1:0][7:0] mem;
		logic [FIFO_AW-1:0] wptr;
		logic [FIFO_AW-1:0] rptr;
		logic [FIFO_AW:0] count;
	} fma_fifo_st_t;

	fma_fifo_st_t r_reg, r_next;
	logic do_push, do_pop;

	// Push into a full queue is dropped so stored data survive
	always_comb begin
		r_next = r_reg;
		do_push = push & ~full;
		do_pop = pop & ~empty;
		if (do_push) begin
			r_next.mem[r_reg.wptr] = din;
			r_next.wptr = r_reg.wptr + 1'b1;
		end
		if (do_pop) begin
			r_next.rptr = r_reg.rptr + 1'b1;
		end
		r_next.count = r_reg.count + {{FIFO_AW{1'b0}}, do_push} - {{FIFO_AW{1'b0}}, do_pop};
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign dout = r_reg.mem[r_reg.rptr];
	assign empty = (r_reg.count == '0);
	assign full = (r_reg.count == (FIFO_AW+1)'(FIFO_DEPTH));
	assign level = r_reg.count;
endmodule // fma_fifo

// File: verilog/fma_host_uart_rx.sv
`timescale 1ns/1ps
module fma_host_uart_rx import fma_pkg::*; #(
	parameter int HOST_BIT_CYCLES = HOST_BIT_CYC
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Host serial line, idles high
	input wire logic host_uart_receive_pin,
	// Checked byte, one-cycle valid
	output fma_byte_t host_byte
);
	typedef enum logic [1:0] {RXS_IDLE, RXS_START, RXS_BITS} fma_rxs_t;
	typedef struct packed {
		fma_rxs_t st;
		logic [CNT_W-1:0] cnt;
		logic [3:0] nbit;
		logic [9:0] sh;
		logic pend;
		logic [CNT_W-1:0] dly;
		logic [7:0] hold;
		fma_byte_t out;
	} fma_rx_st_t;

	fma_rx_st_t r_reg, r_next;
	logic tick;

	always_comb begin
		r_next = r_reg;
		r_next.out.valid = 1'b0;
		tick = (r_reg.cnt == CNT_W'(HOST_BIT_CYCLES - 1));
		r_next.cnt = tick ? '0 : r_reg.cnt + 1'b1;
		case (r_reg.st)
			RXS_IDLE: begin
				r_next.cnt = '0;
				if (!host_uart_receive_pin) begin
					r_next.st = RXS_START;
				end
			end
			RXS_START: begin
				if (r_reg.cnt == CNT_W'(HOST_BIT_CYCLES / 2)) begin
					r_next.cnt = '0;
					r_next.nbit = '0;
					r_next.st = host_uart_receive_pin ? RXS_IDLE : RXS_BITS;
				end
			end
			RXS_BITS: begin
				if (tick) begin
					r_next.sh = {host_uart_receive_pin, r_reg.sh[9:1]};
					r_next.nbit = r_reg.nbit + 1'b1;
					if (r_reg.nbit == 4'(CHAR_BITS - 2)) begin
						r_next.st = RXS_IDLE;
					end
				end
			end
			default: r_next.st = RXS_IDLE;
		endcase
		if (r_reg.st == RXS_BITS && tick && r_reg.nbit == 4'(CHAR_BITS - 2)) begin
			r_next.pend = host_uart_receive_pin & (^r_reg.sh[9:1]);
			r_next.hold = r_reg.sh[8:1];
			r_next.dly = '0;
		end else if (r_reg.pend) begin
			r_next.dly = r_reg.dly + 1'b1;
			if (r_reg.dly == CNT_W'(HOST_QUEUE_BITS * HOST_BIT_CYCLES - 1)) begin
				r_next.pend = 1'b0;
				r_next.out.valid = 1'b1;
				r_next.out.data = r_reg.hold;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign host_byte = r_reg.out;
endmodule // fma_host_uart_rx

// File: verilog/fma_arbiter.sv
// The AHB-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module fma_arbiter import fma_pkg::*; #(
	parameter int BIT_CYCLES = BIT_CYC,
	parameter int MARK_HALF = MARK_HALF_CYC,
	parameter int SPACE_HALF = SPACE_HALF_CYC,
	parameter int HOST_BIT_CYCLES = HOST_BIT_CYC
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// Host handshake
	input wire logic rts_n,
	input wire logic host_uart_receive_pin,
	output logic carrier_detect,
	// Demodulator side
	input wire logic carrier_valid,
	input wire fma_byte_t demod_byte,
	input wire logic rx_pin_filtered,
	output logic receive_input_filtered,
	output logic demod_enable,
	// Modulator side
	output logic modulator_enable,
	output logic modulator_output
);
	typedef struct packed {
		fma_arb_t arb;
		fma_cfg_t cfg;
		logic cts;
		logic cd;
		logic mod_en;
		logic demod_en;
		logic tone;
		logic rx_loop;
		logic [CNT_W-1:0] bit_cnt;
		logic [CNT_W-1:0] tone_cnt;
		logic [3:0] bits_left;
		logic [CHAR_BITS-1:0] shreg;
		logic ph_act;
		logic ph_write;
		logic [3:0] ph_sel;
		logic [31:0] rdata;
		logic ready;
	} fma_arb_st_t;

	fma_arb_st_t r_reg, r_next;
	fma_byte_t host_byte;
	logic tx_push, tx_pop, tx_empty, tx_full;
	logic rx_push, rx_pop, rx_empty, rx_full;
	logic [7:0] tx_din, tx_dout, rx_dout;
	logic [FIFO_AW:0] tx_level, rx_level;
	logic duplex, rts, take, cur_bit, bit_end;
	logic [3:0] sel;
	logic [CNT_W-1:0] half;

	// One-hot register select; zero for unmapped words
	function automatic logic [3:0] reg_decode(input logic [31:0] a);
		logic [3:0] s;
		s = 4'h0;
		if (a[31:8] == 24'h0) begin
			case (a[7:0])
				OFS_CFG: s = 4'h1;
				OFS_STATUS: s = 4'h2;
				OFS_TXWR: s = 4'h4;
				OFS_RXRD: s = 4'h8;
				default: s = 4'h0;
			endcase
		end
		return s;
	endfunction

	fma_host_uart_rx #(
		.HOST_BIT_CYCLES(HOST_BIT_CYCLES)
	) u_host_rx (
		.hclk(hclk),
		.hresetn(hresetn),
		.host_uart_receive_pin(host_uart_receive_pin),
		.host_byte(host_byte)
	);

	fma_fifo u_transmit_fifo (
		.hclk(hclk),
		.hresetn(hresetn),
		.push(tx_push),
		.din(tx_din),
		.pop(tx_pop),
		.dout(tx_dout),
		.empty(tx_empty),
		.full(tx_full),
		.level(tx_level)
	);

	fma_fifo u_receive_fifo (
		.hclk(hclk),
		.hresetn(hresetn),
		.push(rx_push),
		.din(demod_byte.data),
		.pop(rx_pop),
		.dout(rx_dout),
		.empty(rx_empty),
		.full(rx_full),
		.level(rx_level)
	);

	always_comb begin
		r_next = r_reg;
		tx_push = 1'b0;
		tx_din = host_byte.data;
		rx_pop = 1'b0;
		tx_pop = 1'b0;
		duplex = r_reg.cfg.int_loop | r_reg.cfg.external_loopback_enable;
		rts = ~rts_n | r_reg.cfg.rts;
		take = hsel & hready & htrans[1];
		sel = reg_decode(haddr);

		// Bus: zero wait states, reads answered at address phase
		r_next.ready = 1'b1;
		r_next.ph_act = take;
		r_next.ph_write = hwrite;
		r_next.ph_sel = sel;
		if (r_reg.ph_act && r_reg.ph_write) begin
			if (r_reg.ph_sel[0]) begin
				r_next.cfg = fma_cfg_t'(hwdata[CFG_W-1:0]);
			end
			if (r_reg.ph_sel[2] && r_reg.cfg.spi_only) begin
				tx_push = 1'b1;
				tx_din = hwdata[7:0];
			end
		end
		if (host_byte.valid && !r_reg.cfg.spi_only) begin
			tx_push = 1'b1;
		end
		if (take && !hwrite) begin
			r_next.rdata = 32'h0;
			if (sel[0]) begin
				r_next.rdata[CFG_W-1:0] = r_reg.cfg;
			end
			if (sel[1]) begin
				r_next.rdata[ST_CD] = r_reg.cd;
				r_next.rdata[ST_CTS] = r_reg.cts;
				r_next.rdata[ST_MOD_EN] = r_reg.mod_en;
				r_next.rdata[ST_DEMOD_EN] = r_reg.demod_en;
				r_next.rdata[ST_TX_EMPTY] = tx_empty;
				r_next.rdata[ST_TX_FULL] = tx_full;
				r_next.rdata[ST_RX_EMPTY] = rx_empty;
				r_next.rdata[ST_RX_FULL] = rx_full;
				r_next.rdata[ST_TX_LVL +: FIFO_AW+1] = tx_level;
				r_next.rdata[ST_RX_LVL +: FIFO_AW+1] = rx_level;
			end
			// Reading the data word pops it; empty flag shows data is stale
			if (sel[3]) begin
				r_next.rdata[7:0] = rx_dout;
				r_next.rdata[RXRD_EMPTY] = rx_empty;
				rx_pop = 1'b1;
			end
		end

		// Arbitration
		case (r_reg.arb)
			ARB_IDLE: begin
				if (duplex) begin
					r_next.arb = ARB_DUPLEX;
				end else if (carrier_valid) begin
					r_next.arb = ARB_RECEIVE;
				end else if (rts) begin
					r_next.arb = ARB_TRANSMIT;
				end
			end
			ARB_RECEIVE: begin
				// request stays pending here
				// Loopback taken at once, no idle cycle between
				if (duplex) begin
					r_next.arb = ARB_DUPLEX;
				end else if (!carrier_valid) begin
					r_next.arb = ARB_IDLE;
				end
			end
			ARB_TRANSMIT: begin
				if (duplex) begin
					r_next.arb = ARB_DUPLEX;
				end else if (!rts) begin
					r_next.arb = ARB_IDLE;
				end
			end
			ARB_DUPLEX: begin
				if (!duplex) begin
					r_next.arb = ARB_IDLE;
				end
			end
			default: r_next.arb = ARB_IDLE;
		endcase

		// idle keeps demodulator and low detect
		r_next.mod_en = (r_next.arb == ARB_TRANSMIT) || (r_next.arb == ARB_DUPLEX);
		r_next.demod_en = (r_next.arb != ARB_TRANSMIT);
		r_next.cd = (r_next.arb == ARB_RECEIVE) || (r_next.arb == ARB_DUPLEX && carrier_valid);
		r_next.cts = r_next.mod_en;

		bit_end = (r_reg.bit_cnt == CNT_W'(BIT_CYCLES - 1));
		cur_bit = (r_reg.bits_left != 4'h0) ? r_reg.shreg[0] : 1'b1;
		if (!r_reg.mod_en) begin
			r_next.bit_cnt = '0;
			r_next.bits_left = 4'h0;
			r_next.shreg = '1;
		end else if (r_reg.bits_left == 4'h0 && !tx_empty) begin
			tx_pop = 1'b1;
			r_next.shreg = {1'b1, ~^tx_dout, tx_dout, 1'b0};
			r_next.bits_left = 4'(CHAR_BITS);
			r_next.bit_cnt = '0;
		end else if (bit_end) begin
			r_next.bit_cnt = '0;
			if (r_reg.bits_left != 4'h0) begin
				r_next.shreg = {1'b1, r_reg.shreg[CHAR_BITS-1:1]};
				r_next.bits_left = r_reg.bits_left - 1'b1;
			end
		end else begin
			r_next.bit_cnt = r_reg.bit_cnt + 1'b1;
		end

		half = cur_bit ? CNT_W'(MARK_HALF - 1) : CNT_W'(SPACE_HALF - 1);
		if (!r_reg.mod_en) begin
			r_next.tone = 1'b0;
			r_next.tone_cnt = '0;
		end else if (r_reg.tone_cnt >= half) begin
			r_next.tone = ~r_reg.tone;
			r_next.tone_cnt = '0;
		end else begin
			r_next.tone_cnt = r_reg.tone_cnt + 1'b1;
		end

		r_next.rx_loop = r_reg.cfg.int_loop ? r_reg.tone : rx_pin_filtered;
	end

	assign rx_push = demod_byte.valid & r_reg.demod_en;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r_reg <= '0;
			r_reg.arb <= ARB_IDLE;
			r_reg.cfg <= fma_cfg_t'(CFG_RESET);
			r_reg.demod_en <= 1'b1;
			r_reg.shreg <= '1;
			r_reg.ready <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	assign hreadyout = r_reg.ready;
	assign hrdata = r_reg.rdata;
	assign hresp = 1'b0;
	assign carrier_detect = r_reg.cd;
	assign receive_input_filtered = r_reg.rx_loop;
	assign demod_enable = r_reg.demod_en;
	assign modulator_enable = r_reg.mod_en;
	assign modulator_output = r_reg.tone;
endmodule // fma_arbiter

// File: sim/fma_host_model.sv
`timescale 1ns/1ps
module fma_host_model import fma_pkg::*; #(
	parameter int HOST_BIT_CYCLES = 40
) (
	// Clock
	input wire logic hclk,
	// Host lines, both idle high
	output logic host_uart_receive_pin,
	output logic rts_n
);
	initial begin
		host_uart_receive_pin = 1'b1;
		rts_n = 1'b1;
	end
	// start, lsb first, odd parity, stop
	task automatic send(input logic [7:0] d);
		logic [10:0] f;
		f = {1'b1, ~^d, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			@(posedge hclk);
			host_uart_receive_pin <= f[i];
			repeat (HOST_BIT_CYCLES - 1) @(posedge hclk);
		end
		@(posedge hclk);
	endtask
	// pin request, dropped only when told
	task automatic request(input logic on);
		@(posedge hclk);
		rts_n <= ~on;
	endtask
endmodule // fma_host_model

// File: sim/fma_arbiter_sva.sv
`timescale 1ns/1ps
module fma_arbiter_sva import fma_pkg::*; (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	// Link
	input wire logic rts_n,
	input wire logic carrier_valid,
	input wire logic rx_pin_filtered,
	input wire logic carrier_detect,
	input wire logic receive_input_filtered,
	input wire logic demod_enable,
	input wire logic modulator_enable,
	input wire logic modulator_output
);
	logic cfg_ph, int_q, ext_q, loop_q;
	// Shadow of the loopback bits, taken from bus writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_ph <= 1'b0;
			int_q <= 1'b0;
			ext_q <= 1'b0;
		end else begin
			cfg_ph <= hsel && hready && htrans[1] && hwrite && haddr == {24'h0, OFS_CFG};
			if (cfg_ph) begin
				int_q <= hwdata[1];
				ext_q <= hwdata[2];
			end
		end
	end
	assign loop_q = int_q | ext_q;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	half_duplex_a: assert property (!loop_q && !$past(loop_q) |-> !(modulator_enable && demod_enable))
		else $error("both halves on");
	reset_state_a: assert property ($rose(hresetn) |-> demod_enable && !modulator_enable && !carrier_detect)
		else $error("bad state after reset");
	loop_both_a: assert property (loop_q && $past(loop_q) |-> modulator_enable && demod_enable)
		else $error("loopback not both halves");
	int_route_a: assert property ($past(hresetn) && int_q && $past(int_q) |->
		receive_input_filtered == $past(modulator_output))
		else $error("internal loop not routed");
	no_short_a: assert property ($past(hresetn) && !int_q && !$past(int_q) |->
		receive_input_filtered == $past(rx_pin_filtered))
		else $error("receive path shorted");
	detect_rise_a: assert property ($rose(carrier_valid) && !modulator_enable |=> carrier_detect)
		else $error("detect not raised");
	rx_hold_a: assert property (carrier_detect && carrier_valid && !loop_q |=>
		carrier_detect && demod_enable && !modulator_enable)
		else $error("receive left with carrier");
	detect_drop_a: assert property ($fell(carrier_valid) |=> !carrier_detect)
		else $error("detect not dropped");
	grant_send_a: assert property (!rts_n && !carrier_valid && !carrier_detect && !loop_q |=>
		modulator_enable && !demod_enable && !carrier_detect)
		else $error("send not granted");
	mod_quiet_a: assert property (!modulator_enable && !$past(modulator_enable) |-> !modulator_output)
		else $error("tone while disabled");
	cover property ($rose(carrier_detect));
	cover property ($rose(modulator_enable) && !demod_enable);
	cover property (loop_q && modulator_enable && demod_enable);
endmodule // fma_arbiter_sva

bind fma_arbiter fma_arbiter_sva chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .rts_n(rts_n),
	.carrier_valid(carrier_valid), .rx_pin_filtered(rx_pin_filtered), .carrier_detect(carrier_detect),
	.receive_input_filtered(receive_input_filtered), .demod_enable(demod_enable),
	.modulator_enable(modulator_enable), .modulator_output(modulator_output));

// File: sim/tb_fsk_modem_duplex_arbiter.sv
`timescale 1ns/1ps
module tb_fsk_modem_duplex_arbiter import fma_pkg::*;;
	localparam int BC = 40;
	localparam int MH = 20;
	localparam int SH = 11;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hwrite = 1'b0;
	logic hsel = 1'b0;
	logic [2:0] hsize = 3'h0;
	logic carrier_valid = 1'b0;
	logic rx_line = 1'b0;
	logic board_short = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] rd;
	logic [1:0] htrans = 2'h0;
	fma_byte_t demod_byte = '0;
	logic hreadyout, hresp, uart_pin, rts_n, carrier_detect, rif, demod_enable, modulator_enable, modulator_output;
	logic [31:0] hrdata;
	wire logic rx_pin_filtered;
	int errors = 0;
	int total_checks = 0;
	assign rx_pin_filtered = board_short ? modulator_output : rx_line;

	fma_arbiter #(.BIT_CYCLES(BC), .MARK_HALF(MH), .SPACE_HALF(SH), .HOST_BIT_CYCLES(BC)) dut_u (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .rts_n(rts_n), .host_uart_receive_pin(uart_pin), .carrier_detect(carrier_detect),
		.carrier_valid(carrier_valid), .demod_byte(demod_byte), .rx_pin_filtered(rx_pin_filtered),
		.receive_input_filtered(rif), .demod_enable(demod_enable), .modulator_enable(modulator_enable),
		.modulator_output(modulator_output));
	fma_host_model #(.HOST_BIT_CYCLES(BC)) host_u (.hclk(hclk), .host_uart_receive_pin(uart_pin), .rts_n(rts_n));

	initial begin
		forever #5 hclk = ~hclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// Address phase held until ready, then data phase until ready
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		hsize <= 3'h2;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string w);
		bus(1'b0, a, 32'h0);
		chk(rd & m, e, w);
	endtask

	// Cycles until the tone changes level, bounded
	task automatic tog(output int n);
		logic p;
		p = modulator_output;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (modulator_output === p && n < 200);
	endtask

	task automatic t_reset;
		chk({carrier_detect, demod_enable, modulator_enable, modulator_output}, 4'h4, "reset pins");
		rdchk(OFS_CFG, 32'hf, 32'h0, "cfg reset");
		rdchk(OFS_STATUS, 32'hff, 32'h58, "idle status");
		rdchk(OFS_RXRD, 32'h1ff, 32'h100, "rx empty read");
		bus(1'b1, 8'h10, 32'hffffffff);
		rdchk(8'h10, 32'hffffffff, 32'h0, "unmapped");
		$display("test reset done");
	endtask

	task automatic t_receive;
		int n;
		@(posedge hclk);
		carrier_valid <= 1'b1;
		repeat (2) @(posedge hclk);
		chk(carrier_detect, 1'b1, "detect up");
		host_u.request(1'b1);
		@(posedge hclk);
		demod_byte <= {1'b1, 8'ha5};
		@(posedge hclk);
		demod_byte <= '0;
		repeat (4) @(posedge hclk);
		chk({carrier_detect, demod_enable, modulator_enable}, 3'b110, "pending");
		rdchk(OFS_STATUS, 32'h20, 32'h0, "tx room");
		rdchk(OFS_RXRD, 32'h1ff, 32'h0a5, "rx byte");
		@(posedge hclk);
		carrier_valid <= 1'b0;
		repeat (4) @(posedge hclk);
		chk({carrier_detect, demod_enable, modulator_enable}, 3'b001, "grant");
		rdchk(OFS_STATUS, 32'h3, 32'h2, "cts");
		tog(n);
		tog(n);
		chk(n, MH, "mark half");
		host_u.request(1'b0);
		repeat (3) @(posedge hclk);
		chk({carrier_detect, demod_enable, modulator_enable}, 3'b010, "idle again");
		$display("test receive done");
	endtask

	task automatic t_spi;
		int n;
		bus(1'b1, OFS_TXWR, 32'h0);
		rdchk(OFS_STATUS, 32'h10, 32'h10, "txwr ignored");
		bus(1'b1, OFS_CFG, 32'h8);
		bus(1'b1, OFS_TXWR, 32'h0);
		rdchk(OFS_STATUS, 32'h3f10, 32'h100, "queued");
		bus(1'b1, OFS_CFG, 32'h9);
		tog(n);
		tog(n);
		chk(n, SH, "start space");
		repeat (300) @(posedge hclk);
		tog(n);
		tog(n);
		chk(n, SH, "data space");
		repeat (30) @(posedge hclk);
		tog(n);
		tog(n);
		chk(n, MH, "parity mark");
		bus(1'b1, OFS_CFG, 32'h0);
		repeat (3) @(posedge hclk);
		chk({demod_enable, modulator_enable, modulator_output}, 3'b100, "stopped");
		$display("test spi done");
	endtask

	task automatic t_loop;
		int n;
		bus(1'b1, OFS_CFG, 32'h2);
		repeat (2) @(posedge hclk);
		chk({demod_enable, modulator_enable}, 2'b11, "int loop");
		// Both tone phases, so one differs from the idle pin
		tog(n);
		@(posedge hclk);
		chk(rif, modulator_output, "loop route a");
		tog(n);
		@(posedge hclk);
		chk(rif, modulator_output, "loop route b");
		repeat (60) @(posedge hclk);
		board_short <= 1'b1;
		bus(1'b1, OFS_CFG, 32'h4);
		repeat (60) @(posedge hclk);
		chk({demod_enable, modulator_enable}, 2'b11, "ext loop");
		bus(1'b1, OFS_CFG, 32'h0);
		board_short <= 1'b0;
		repeat (2) @(posedge hclk);
		chk({demod_enable, modulator_enable}, 2'b10, "half duplex");
		rx_line <= 1'b1;
		repeat (2) @(posedge hclk);
		chk(rif, 1'b1, "pin path");
		rx_line <= 1'b0;
		$display("test loop done");
	endtask

	task automatic t_host;
		host_u.send(8'h3c);
		repeat (50) @(posedge hclk);
		rdchk(OFS_STATUS, 32'h10, 32'h10, "too early");
		repeat (20) @(posedge hclk);
		rdchk(OFS_STATUS, 32'h3f10, 32'h100, "host queued");
		host_u.request(1'b1);
		repeat (3) @(posedge hclk);
		rdchk(OFS_STATUS, 32'h10, 32'h10, "popped");
		repeat (11 * BC) @(posedge hclk);
		host_u.request(1'b0);
		$display("test host done");
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset;
		t_receive;
		t_spi;
		t_loop;
		t_host;
		tally_and_finish;
	end

	// Whole run is about 1700 cycles
	initial begin
		repeat (20000) @(posedge hclk);
		errors++;
		$display("CHECK FAILED %0t watchdog", $time);
		tally_and_finish;
	end
endmodule // tb_fsk_modem_duplex_arbiter
